// [hdl/umt_link_tx.sv]
// Purpose: Link-clock side: drives cell or nibble outputs per request
// Assumes: Mode and enable are quasi-static, synchronised here
// Notes:   All outputs change on the rising link clock edge
`timescale 1ns/1ps
module umt_link_tx #(
	parameter int DATA_W = umt_pkg::DATA_W,
	parameter int ADDR_W = umt_pkg::ADDR_W
) (
	input  wire logic      linkClk,
	input  wire logic      linkRstN,
	input  wire logic      enableAsync,
	input  wire logic      modeAsync,
	input  wire logic      multiPhyAsync,
	umt_xfer_if.link       xfer,
	output logic [DATA_W-1:0] txData,
	output logic [ADDR_W-1:0] txAddr,
	output logic           txEnable,
	output logic           txStart,
	output logic           txValid,
	output logic           outEnN
);
	typedef enum logic [1:0] {
		LNK_IDLE,
		LNK_SELECT,
		LNK_SEND,
		LNK_ACK
	} umt_lnk_state_t;

	logic           enable;
	logic           mode;
	logic           multiPhy;
	logic           reqS;
	logic           reqSeen;
	logic           pending;
	localparam int NIB_CNT_W = 5;

	logic [NIB_CNT_W-1:0] nibCount;
	logic           onHigh;
	logic [DATA_W-1:0] nibByte;
	logic           nibLast;
	umt_lnk_state_t state;

	umt_sync3 u_en (.clk(linkClk), .rstN(linkRstN), .async(enableAsync), .synced(enable));
	umt_sync3 u_md (.clk(linkClk), .rstN(linkRstN), .async(modeAsync), .synced(mode));
	umt_sync3 u_mp (.clk(linkClk), .rstN(linkRstN), .async(multiPhyAsync), .synced(multiPhy));
	umt_sync3 u_rq (.clk(linkClk), .rstN(linkRstN), .async(xfer.reqToggle), .synced(reqS));

	assign pending = (reqS != reqSeen);

	// Pins float until software enables the port
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			outEnN <= 1'b1; // RULE10
		end else begin
			outEnN <= !enable; // RULE10
		end
	end

	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			state     <= LNK_IDLE;
			reqSeen   <= 1'b0;
			xfer.ackToggle <= 1'b0;
			txData    <= '0;
			txAddr    <= '0;
			txEnable  <= 1'b0;
			txStart   <= 1'b0;
			txValid   <= 1'b0;
			nibCount  <= '0;
			onHigh    <= 1'b0;
			nibByte   <= '0;
			nibLast   <= 1'b0;
		end else begin
			txStart <= 1'b0;
			case (state)
				LNK_IDLE: begin
					// Enable line idles high in cell mode when nothing is pending; it stays low in nibble mode
					txEnable <= (mode == umt_pkg::UMT_MODE_CELL) && !pending;
					if (pending && enable) begin
						reqSeen <= reqS;
						if (mode == umt_pkg::UMT_MODE_NIBBLE) begin
							// Copied and answered at once, so the next byte arrives while this one shifts
							xfer.ackToggle <= !xfer.ackToggle;
							nibByte        <= xfer.reqData;
							nibLast        <= xfer.reqLast;
							// Preamble and SFD precede the byte stream
							if (xfer.reqFirst && !txValid) begin
								txData   <= DATA_W'(umt_pkg::PREAMBLE_NIBBLE); // RULE6
								txValid  <= 1'b1; // RULE9
								nibCount <= NIB_CNT_W'(1);
								state    <= LNK_SEND;
							end else begin
								txData <= DATA_W'(xfer.reqData[umt_pkg::NIBBLE_W-1:0]); // RULE6
								onHigh <= 1'b1;
								state  <= LNK_SEND;
							end
						end else if (multiPhy && xfer.reqFirst) begin
							txAddr   <= xfer.reqAddr; // RULE1
							txEnable <= 1'b1; // RULE1
							state    <= LNK_SELECT;
						end else begin
							txData   <= xfer.reqData; // RULE5 RULE7
							txStart  <= xfer.reqFirst; // RULE4
							txEnable <= 1'b0; // RULE2 RULE3
							state    <= LNK_ACK;
						end
					end
				end
				LNK_SELECT: begin
					txEnable <= 1'b0; // RULE1 RULE3
					txData   <= xfer.reqData; // RULE5
					txStart  <= 1'b1; // RULE4
					state    <= LNK_ACK;
				end
				LNK_SEND: begin
					if (nibCount != '0) begin
						if (nibCount == NIB_CNT_W'(umt_pkg::PREAMBLE_NIB)) begin
							txData   <= DATA_W'(umt_pkg::SFD_NIBBLE);
							nibCount <= '0;
							onHigh   <= 1'b0;
						end else begin
							txData   <= DATA_W'(umt_pkg::PREAMBLE_NIBBLE);
							nibCount <= nibCount + NIB_CNT_W'(1);
						end
					end else if (!onHigh) begin
						txData <= DATA_W'(nibByte[umt_pkg::NIBBLE_W-1:0]); // RULE6
						onHigh <= 1'b1;
					end else begin
						txData <= DATA_W'(nibByte[DATA_W-1:umt_pkg::NIBBLE_W]); // RULE6
						onHigh <= 1'b0;
						state  <= LNK_ACK;
					end
				end
				LNK_ACK: begin
					if (mode == umt_pkg::UMT_MODE_NIBBLE) begin
						if (nibLast) begin
							txValid <= 1'b0; // RULE9
							state   <= LNK_IDLE;
						end else if (pending && enable) begin
							// Next byte follows with no idle nibble in between
							reqSeen        <= reqS;
							xfer.ackToggle <= !xfer.ackToggle;
							nibByte        <= xfer.reqData;
							nibLast        <= xfer.reqLast;
							txData         <= DATA_W'(xfer.reqData[umt_pkg::NIBBLE_W-1:0]); // RULE6 RULE9
							onHigh         <= 1'b1;
							state          <= LNK_SEND;
						end else begin
							// Underrun: a late byte leaves the last nibble repeated
							state <= LNK_IDLE;
						end
					end else begin
						xfer.ackToggle <= !xfer.ackToggle;
						// No byte stands on the bus now, so enable returns high
						txEnable       <= 1'b1; // RULE3
						state          <= LNK_IDLE;
					end
				end
				default: state <= LNK_IDLE;
			endcase
		end
	end
endmodule

// [hdl/umt_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is a level from another domain
// Notes:   Stage one feeds only stage two
`timescale 1ns/1ps
module umt_sync3 (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic async,
	output logic      synced
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= async;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			synced <= 1'b0;
		end else if (s2 == s3) begin
			synced <= s3;
		end
	end
endmodule

// [hdl/umt_tx_port.sv]
// Purpose: Transmit port top: core byte stream out over cell or nibble pins
// Assumes: Link clock supplied externally; 25 or 2.5 MHz in nibble mode
// Notes:   Byte interface stalls via byteReady while a transfer is in flight
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// (RULE1) Multi-PHY: address on bus, enable high one clock, then low selects PHY.
// (RULE2) Single-PHY: enable line only signals readiness to send.
// (RULE3) Enable line low tells the selected PHY cell data is flowing.
// (RULE4) Start marker high exactly with the first valid cell byte.
// (RULE5) Cell bytes leave on the transmit bus, low bits included.
// (RULE6) Nibble mode: low four pins carry the transmit nibble on link clock.
// (RULE7) Cell outputs change on the rising edge of the link clock.
// (RULE8) Far end supplies 25 MHz or 2.5 MHz nibble clock.
// (RULE9) Valid raised at first preamble nibble, held through the frame.
// (RULE10) Outputs float through reset until software enables the port.
module umt_tx_port #(
	parameter int DATA_W = umt_pkg::DATA_W,
	parameter int ADDR_W = umt_pkg::ADDR_W
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	input  wire logic              cellTxClock,
	input  wire logic              portEnable,
	input  wire logic              nibbleMode,
	input  wire logic              multiPhy,
	input  wire logic [DATA_W-1:0] byteData,
	input  wire logic [ADDR_W-1:0] byteAddr,
	input  wire logic              byteFirst,
	input  wire logic              byteLast,
	input  wire logic              byteValid,
	output logic                   byteReady,
	output logic [DATA_W-1:0]      cellTxBus,
	output logic [ADDR_W-1:0]      cellTxPhySelectAddr,
	output logic                   cellTxEnableOut,
	output logic                   cellTxStartMarker,
	output logic                   macATxValid,
	output logic                   txOutEnN
);
	umt_xfer_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) xfer ();

	logic ackS;
	logic busy;
	logic reqToggle;
	logic linkRstMeta;
	logic linkRstN;

	////////////////////////////////////////////////////////////////////////////
	// Reset release into the link domain
	always_ff @(posedge cellTxClock or negedge reset_n) begin
		if (!reset_n) begin
			linkRstMeta <= 1'b0;
			linkRstN    <= 1'b0;
		end else begin
			linkRstMeta <= 1'b1;
			linkRstN    <= linkRstMeta;
		end
	end

	umt_sync3 u_ack (
		.clk    (core_clk),
		.rstN   (reset_n),
		.async  (xfer.ackToggle),
		.synced (ackS)
	);

	////////////////////////////////////////////////////////////////////////////
	// Core side: one byte captured and held until acknowledged
	assign busy      = (reqToggle != ackS);
	assign byteReady = !busy && portEnable;
	assign xfer.reqToggle = reqToggle;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reqToggle     <= 1'b0;
			xfer.reqData  <= '0;
			xfer.reqAddr  <= '0;
			xfer.reqFirst <= 1'b0;
			xfer.reqLast  <= 1'b0;
		end else if (byteValid && byteReady) begin
			xfer.reqData  <= byteData;
			xfer.reqAddr  <= byteAddr;
			xfer.reqFirst <= byteFirst;
			xfer.reqLast  <= byteLast;
			reqToggle     <= !reqToggle;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link side, clocked by the external transmit clock
	umt_link_tx #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_link (
		.linkClk       (cellTxClock), // RULE7 RULE8
		.linkRstN      (linkRstN),
		.enableAsync   (portEnable),
		.modeAsync     (nibbleMode),
		.multiPhyAsync (multiPhy),
		.xfer          (xfer.link),
		.txData        (cellTxBus),
		.txAddr        (cellTxPhySelectAddr),
		.txEnable      (cellTxEnableOut),
		.txStart       (cellTxStartMarker),
		.txValid       (macATxValid),
		.outEnN        (txOutEnN)
	);
endmodule

// [pkg/umt_pkg.sv]
// Purpose: Shared constants and types for the cell/nibble transmit port
// Assumes: Cell bus 8 bits, address bus 5 bits, 53-byte cells
// Notes:   DATA_W and ADDR_W are defaults that modules take as parameters; NIBBLE_W and PREAMBLE_NIB are used directly
package umt_pkg;
	localparam int CELL_BYTES   = 53;
	localparam int DATA_W       = 8;
	localparam int ADDR_W       = 5;
	localparam int NIBBLE_W     = 4;
	localparam int PREAMBLE_NIB = 15;
	localparam int SYNC_STAGES  = 3;
	localparam int CORE_CLK_MHZ = 50;
	localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
	localparam logic [3:0] SFD_NIBBLE      = 4'hD;

	typedef enum logic {
		UMT_MODE_CELL,
		UMT_MODE_NIBBLE
	} umt_mode_t;
endpackage

// [pkg/umt_xfer_if.sv]
// Purpose: Request/answer group between the core side and the link side
// Assumes: Request fields stable while the toggle is in flight
// Notes:   Toggle handshake; one transfer outstanding at a time
`timescale 1ns/1ps
interface umt_xfer_if #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 5
);
	logic              reqToggle;
	logic              ackToggle;
	logic [DATA_W-1:0] reqData;
	logic [ADDR_W-1:0] reqAddr;
	logic              reqFirst;
	logic              reqLast;

	modport core (
		output reqToggle,
		output reqData,
		output reqAddr,
		output reqFirst,
		output reqLast,
		input  ackToggle
	);
	modport link (
		input  reqToggle,
		input  reqData,
		input  reqAddr,
		input  reqFirst,
		input  reqLast,
		output ackToggle
	);
endinterface

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the transmit port
// Assumes: Link clock from the PHY model, unrelated in phase
// Notes:   Reset held 12 core clocks; the link side is reset asynchronously
`timescale 1ns/1ps
module tb_top;
	logic       core_clk = 0, reset_n = 0, portEnable = 0, nibbleMode = 0, multiPhy = 0;
	logic [7:0] byteData = 0;
	logic [4:0] byteAddr = 0;
	logic       byteFirst = 0, byteLast = 0, byteValid = 0;
	logic       cellTxClock, byteReady, cellTxEnableOut, cellTxStartMarker, macATxValid, txOutEnN;
	logic [7:0] cellTxBus;
	logic [4:0] cellTxPhySelectAddr;
	int         n_errors = 0, checked = 0;
	umt_tx_port i_umt_tx_port (.*);
	umt_phy_model i_umt_phy_model (.linkClk(cellTxClock), .outEnN(txOutEnN), .nibbleMode(nibbleMode),
		.bus(cellTxBus), .addr(cellTxPhySelectAddr), .enableOut(cellTxEnableOut),
		.startMarker(cellTxStartMarker), .txValid(macATxValid));
	always #10 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic f, input logic l);
		int n;
		n = 0;
		@(posedge core_clk);
		byteData <= d;
		byteFirst <= f;
		byteLast <= l;
		byteValid <= 1'b1;
		// Ready is judged before the edge to avoid a race with its update
		do @(negedge core_clk); while (byteReady !== 1'b1 && ++n < 4000);
		chk("ready", 8'(byteReady), 8'h01);
		@(posedge core_clk);
		byteValid <= 1'b0;
	endtask
	task automatic t_enable();
		int n;
		n = 0;
		chk("float", 8'(txOutEnN), 8'h01);
		chk("ready", 8'(byteReady), 8'h00);
		@(posedge core_clk);
		portEnable <= 1'b1;
		while (txOutEnN !== 1'b0 && ++n < 400) @(posedge core_clk);
		chk("driven", 8'(txOutEnN), 8'h00);
		$display("test enable done");
	endtask
	task automatic t_cell(input logic mp, input logic [4:0] ad);
		logic [7:0] b[3];
		int         n;
		b = '{8'h00, 8'hA5, 8'hFF};
		n = 0;
		@(posedge core_clk);
		multiPhy <= mp;
		byteAddr <= ad;
		i_umt_phy_model.cellQ.delete();
		i_umt_phy_model.starts = 0;
		repeat (8) @(posedge cellTxClock);
		foreach (b[k]) send(b[k], k == 0, k == 2);
		while (i_umt_phy_model.cellQ.size() < 3 && ++n < 4000) @(posedge core_clk);
		repeat (8) @(posedge cellTxClock);
		chk("cell count", 8'(i_umt_phy_model.cellQ.size()), 8'h03);
		foreach (b[k]) chk("cell byte", i_umt_phy_model.cellQ[k], b[k]);
		chk("starts", 8'(i_umt_phy_model.starts), 8'h01);
		if (mp) chk("phy addr", 8'(i_umt_phy_model.selAddr), 8'(ad));
		chk("idle enable", 8'(i_umt_phy_model.enPin), 8'h01);
		$display("test cell multiPhy=%0d done", mp);
	endtask
	task automatic t_nib();
		logic [3:0] e[$];
		int         n;
		n = 0;
		repeat (15) e.push_back(umt_pkg::PREAMBLE_NIBBLE);
		e = {e, umt_pkg::SFD_NIBBLE, 4'h7, 4'hA, 4'hC, 4'h3};
		@(posedge core_clk);
		nibbleMode <= 1'b1;
		repeat (8) @(posedge cellTxClock);
		send(8'hA7, 1'b1, 1'b0);
		send(8'h3C, 1'b0, 1'b1);
		while (i_umt_phy_model.nibQ.size() < 20 && ++n < 8000) @(posedge core_clk);
		repeat (8) @(posedge cellTxClock);
		chk("nibble count", 8'(i_umt_phy_model.nibQ.size()), 8'(e.size()));
		foreach (e[k]) chk("nibble", 8'(i_umt_phy_model.nibQ[k]), 8'(e[k]));
		$display("test nibble done");
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		t_enable();
		t_cell(1'b1, 5'h1F);
		t_cell(1'b0, 5'h00);
		t_nib();
		give_verdict();
	end
	// Whole run needs well under 100 us; allow twice that
	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end
endmodule
bind umt_tx_port umt_tx_port_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_umt_tx_port_chk (.*);

// [sim/umt_phy_model.sv]
// Purpose: Far-end PHY: supplies the link clock, records what arrives
// Assumes: Pins float while outEnN is high; enable line pulled up
// Notes:   Clock slower than a real one; only its ratio to core matters
`timescale 1ns/1ps
module umt_phy_model (
	output logic                           linkClk,
	input  wire logic                      outEnN,
	input  wire logic                      nibbleMode,
	input  wire logic [umt_pkg::DATA_W-1:0] bus,
	input  wire logic [umt_pkg::ADDR_W-1:0] addr,
	input  wire logic                      enableOut,
	input  wire logic                      startMarker,
	input  wire logic                      txValid
);
	logic [7:0] cellQ[$];
	logic [3:0] nibQ[$];
	logic [4:0] prevAddr;
	logic [4:0] selAddr;
	int         starts = 0;
	wire        enPin = outEnN ? 1'b1 : enableOut;
	initial begin
		linkClk = 1'b0;
		#7;
		forever #80 linkClk = ~linkClk;
	end
	// Sample like the PHY: old values at the rising edge
	always @(posedge linkClk) begin
		prevAddr <= addr;
		if (!nibbleMode && !enPin) cellQ.push_back(bus);
		if (!nibbleMode && !enPin && startMarker) starts++;
		if (!nibbleMode && !enPin && startMarker) selAddr <= prevAddr;
		if (nibbleMode && txValid && !outEnN) nibQ.push_back(bus[3:0]);
	end
endmodule

// [sim/umt_tx_port_chk.sv]
// Purpose: Port-level checks for the transmit port
// Assumes: Mode pins held still while traffic runs
// Notes:   Link-side checks are clocked on the link clock, except link_edge_only_a, which samples on core_clk
`timescale 1ns/1ps
module umt_tx_port_chk #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 5
) (
	input wire logic              core_clk,
	input wire logic              reset_n,
	input wire logic              cellTxClock,
	input wire logic              portEnable,
	input wire logic              nibbleMode,
	input wire logic              multiPhy,
	input wire logic              byteReady,
	input wire logic              byteValid,
	input wire logic [DATA_W-1:0] cellTxBus,
	input wire logic [ADDR_W-1:0] cellTxPhySelectAddr,
	input wire logic              cellTxEnableOut,
	input wire logic              cellTxStartMarker,
	input wire logic              macATxValid,
	input wire logic              txOutEnN
);
	sequence preambleRun;
		(macATxValid && cellTxBus[3:0] == umt_pkg::PREAMBLE_NIBBLE)[*8];
	endsequence
	float_until_en_a: assert property (@(posedge cellTxClock) disable iff (!reset_n)
		$fell(txOutEnN) |-> $past(portEnable, 2)) else $error("pins driven without enable");
	ready_needs_en_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		byteReady |-> portEnable) else $error("ready while disabled");
	take_one_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		byteValid && byteReady |=> !byteReady) else $error("second byte taken before answer");
	start_enable_low_a: assert property (@(posedge cellTxClock) disable iff (!reset_n)
		cellTxStartMarker |-> !cellTxEnableOut && !nibbleMode) else $error("start without data");
	start_one_clock_a: assert property (@(posedge cellTxClock) disable iff (!reset_n)
		cellTxStartMarker |=> !cellTxStartMarker) else $error("start marker too long");
	phy_select_a: assert property (@(posedge cellTxClock) disable iff (!reset_n)
		$rose(cellTxStartMarker) && multiPhy |-> $past(cellTxEnableOut) && $stable(cellTxPhySelectAddr))
		else $error("no select clock before cell");
	valid_nibble_a: assert property (@(posedge cellTxClock) disable iff (!reset_n)
		macATxValid |-> nibbleMode) else $error("valid in cell mode");
	preamble_hold_a: assert property (@(posedge cellTxClock) disable iff (!reset_n)
		$rose(macATxValid) |-> preambleRun) else $error("preamble not held");
	link_edge_only_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!$rose(cellTxClock) |-> $stable({cellTxBus, cellTxPhySelectAddr, cellTxEnableOut,
		cellTxStartMarker, macATxValid})) else $error("output moved off link edge");
endmodule
